//--- logic/brake_power_sequencer.sv
// Holding brake and motor power sequencer with an Avalon-MM register slave.
//
// Design decisions made here: the Avalon-MM register port and the register offsets.
`include "bps_defs.svh"

// Behaviour
// - Wait first delay from power-on to release.
// - Wait second delay from release to ready.
// - Hold early motion commands until ready.
// - Wait third delay from stop to engage.
// - Wait fourth delay from engage to power-off.
// - Sequence brake only when enable flag set.
// - Cut motor power only when flag set or control bit clear.
// - Brake counts only when present bit set.
// - Hold-when-energised bit sets drive polarity.
module brake_power_sequencer
  import bps_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'(`BPS_TICK_CYC)
) (
  input  wire logic        ref_clk,          // System clock, 25 MHz.
  input  wire logic        rst,              // Synchronous reset, active high.
  input  wire logic [2:0]  avs_address,      // Register word index.
  input  wire logic        avs_read,         // Read request.
  input  wire logic        avs_write,        // Write request.
  input  wire logic [31:0] avs_writedata,    // Write data.
  output logic      [31:0] avs_readdata,     // Read data.
  output logic             avs_waitrequest,  // Stall until the access is done.
  input  wire logic        move_cmd,         // One-cycle motion command.
  input  wire logic        motion_active,    // High while the motor moves.
  output logic             motor_power_en,   // Motor power switch on.
  output logic             brake_drive,      // Brake driver output.
  output logic             move_ready,       // Brake released, motion allowed.
  output logic             move_go           // One-cycle release of a command.
);

  bps_seq_t  q;
  bps_seq_t  n;
  bps_tmr_if tif ();

  bps_ms_timer #(.TICK_CYCLES(TICK_CYCLES)) u_timer (
    .ref_clk (ref_clk),
    .rst     (rst),
    .tmr     (tif.tmr)
  );

  always_comb begin
    logic        active;
    logic        start;
    logic        tstart;
    logic [15:0] tlen;
    logic [31:0] rd;
    active = q.flags[`BPS_BF_ENABLE] & q.acc[`BPS_ACC_PRESENT];
    start  = move_cmd | (q.preq & ~q.preq_prev);
    tstart = 1'b0;
    tlen   = q.power_on_to_release_delay;
    rd     = 32'h0000_0000;
    n           = q;
    n.go        = 1'b0;
    n.preq_prev = q.preq;
    n.moving    = motion_active;

    // One wait state: data is latched on the first edge, writes land on the second.
    if (avs_address == `BPS_REG_DLY01) begin
      rd = {q.release_to_ready_delay, q.power_on_to_release_delay};
    end else if (avs_address == `BPS_REG_DLY23) begin
      rd = {q.engage_to_power_off_delay, q.stop_to_engage_delay};
    end else if (avs_address == `BPS_REG_FLAGS) begin
      rd = {24'h00_0000, q.flags};
    end else if (avs_address == `BPS_REG_ACC) begin
      rd = q.acc;
    end else if (avs_address == `BPS_REG_CTRL) begin
      rd = {31'h0000_0000, q.preq};
    end else if (avs_address == `BPS_REG_STATUS) begin
      rd = {25'h000_0000, q.engaged, q.power, q.ready, q.pend, q.st};
    end
    if ((avs_read | avs_write) & q.wreq) begin
      n.wreq  = 1'b0;
      n.rdata = rd;
    end else if (!q.wreq) begin
      n.wreq = 1'b1;
      if (avs_write) begin
        if (avs_address == `BPS_REG_DLY01) begin
          n.power_on_to_release_delay = avs_writedata[15:0];
          n.release_to_ready_delay    = avs_writedata[31:16];
        end else if (avs_address == `BPS_REG_DLY23) begin
          n.stop_to_engage_delay      = avs_writedata[15:0];
          n.engage_to_power_off_delay = avs_writedata[31:16];
        end else if (avs_address == `BPS_REG_FLAGS) begin
          n.flags = avs_writedata[7:0];
        end else if (avs_address == `BPS_REG_ACC) begin
          n.acc = avs_writedata;
        end else if (avs_address == `BPS_REG_CTRL) begin
          n.preq = avs_writedata[`BPS_CTRL_PWR];
        end
      end
    end

    if (!active) begin
      // Without an enabled, present brake, power simply follows the control bit.
      n.st      = q.preq ? BPS_READY : BPS_OFF;
      n.power   = q.preq;
      n.ready   = q.preq;
      n.engaged = 1'b0;
      n.pend    = 1'b0;
      n.go      = move_cmd & q.preq;
    end else begin
      case (q.st)
        BPS_OFF: begin
          if (start) begin
            n.st      = BPS_PWR_WAIT;
            n.power   = 1'b1;
            n.engaged = 1'b1;
            n.pend    = move_cmd;
            tstart    = 1'b1;
            tlen      = q.power_on_to_release_delay;
          end
        end
        BPS_PWR_WAIT: begin
          if (move_cmd) begin
            n.pend = 1'b1;
          end
          if (tif.done) begin
            n.st      = BPS_REL_WAIT;
            n.engaged = 1'b0;
            tstart    = 1'b1;
            tlen      = q.release_to_ready_delay;
          end
        end
        BPS_REL_WAIT: begin
          if (move_cmd) begin
            n.pend = 1'b1;
          end
          if (tif.done) begin
            n.st    = BPS_READY;
            n.ready = 1'b1;
            n.go    = q.pend | move_cmd;
            n.pend  = 1'b0;
          end
        end
        BPS_READY: begin
          // A move released last cycle has not raised motion_active yet, so it is no stop.
          if (move_cmd) begin
            n.go = 1'b1;
          end else if (!q.go & !motion_active & (q.moving | ~q.preq)) begin
            n.st   = BPS_STOP_WAIT;
            tstart = 1'b1;
            tlen   = q.stop_to_engage_delay;
          end
        end
        BPS_STOP_WAIT: begin
          // The brake is still open here, so a new command runs at once.
          if (move_cmd) begin
            n.st = BPS_READY;
            n.go = 1'b1;
          end else if (motion_active) begin
            n.st = BPS_READY;
          end else if (tif.done) begin
            n.engaged = 1'b1;
            n.ready   = 1'b0;
            if (q.flags[`BPS_BF_CUTS] | ~q.preq) begin
              n.st   = BPS_ENG_WAIT;
              tstart = 1'b1;
              tlen   = q.engage_to_power_off_delay;
            end else begin
              n.st = BPS_HOLD;
            end
          end
        end
        BPS_ENG_WAIT, BPS_HOLD: begin
          if (move_cmd) begin
            n.st      = BPS_REL_WAIT;
            n.engaged = 1'b0;
            n.pend    = 1'b1;
            tstart    = 1'b1;
            tlen      = q.release_to_ready_delay;
          end else if (q.st == BPS_HOLD) begin
            if (!q.preq) begin
              n.st   = BPS_ENG_WAIT;
              tstart = 1'b1;
              tlen   = q.engage_to_power_off_delay;
            end
          end else if (tif.done) begin
            n.st    = BPS_OFF;
            n.power = 1'b0;
          end
        end
        default: begin
          n.st = BPS_OFF;
        end
      endcase
    end

    // Energise to hold, or energise to release, as the accessory bits say.
    n.drive = n.flags[`BPS_BF_ENABLE] & n.acc[`BPS_ACC_PRESENT] &
              (n.acc[`BPS_ACC_HOLD_EN] ? n.engaged : ~n.engaged);
    tif.start = tstart;
    tif.len   = tlen;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '{st: BPS_OFF, power_on_to_release_delay: `BPS_DLY_RST,
             release_to_ready_delay: `BPS_DLY_RST, stop_to_engage_delay: `BPS_DLY_RST,
             engage_to_power_off_delay: `BPS_DLY_RST, flags: `BPS_FLAGS_RST,
             acc: `BPS_ACC_RST, preq: `BPS_CTRL_RST, wreq: 1'b1, rdata: 32'h0000_0000, default: 1'b0};
    end else begin
      q <= n;
    end
  end

  assign avs_readdata    = q.rdata;
  assign avs_waitrequest = q.wreq;
  assign motor_power_en  = q.power;
  assign brake_drive     = q.drive;
  assign move_ready      = q.ready;
  assign move_go         = q.go;

  // Cycles spent in the current state, for the delay checks below.
  logic [31:0] st_cnt;
  always_ff @(posedge ref_clk) begin
    if (rst || (n.st != q.st)) begin
      st_cnt <= 32'h0000_0000;
    end else begin
      st_cnt <= st_cnt + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_release_delay;
    (q.st == BPS_REL_WAIT) && ($past(q.st) == BPS_PWR_WAIT) &&
      $stable(q.power_on_to_release_delay) |->
      $past(st_cnt) == 32'($past(q.power_on_to_release_delay)) * 32'(TICK_CYCLES);
  endproperty
  a_release_delay: assert property (p_release_delay) else $error("release delay wrong");

  property p_ready_delay;
    $rose(q.ready) && ($past(q.st) == BPS_REL_WAIT) && $stable(q.release_to_ready_delay) |->
      $past(st_cnt) == 32'($past(q.release_to_ready_delay)) * 32'(TICK_CYCLES);
  endproperty
  a_ready_delay: assert property (p_ready_delay) else $error("ready delay wrong");

  property p_go_only_ready;
    q.go |-> q.ready;
  endproperty
  a_go_only_ready: assert property (p_go_only_ready) else $error("command ran early");

  property p_engage_delay;
    ($past(q.st) == BPS_STOP_WAIT) && (q.st inside {BPS_ENG_WAIT, BPS_HOLD}) &&
      $stable(q.stop_to_engage_delay) |->
      $past(st_cnt) == 32'($past(q.stop_to_engage_delay)) * 32'(TICK_CYCLES);
  endproperty
  a_engage_delay: assert property (p_engage_delay) else $error("engage delay wrong");

  property p_poweroff_delay;
    ($past(q.st) == BPS_ENG_WAIT) && (q.st == BPS_OFF) && $stable(q.engage_to_power_off_delay) |->
      $past(st_cnt) == 32'($past(q.engage_to_power_off_delay)) * 32'(TICK_CYCLES);
  endproperty
  a_poweroff_delay: assert property (p_poweroff_delay) else $error("power-off delay wrong");

  property p_disabled_idle;
    !q.flags[`BPS_BF_ENABLE] && $stable(q.flags) |-> !brake_drive && !q.engaged;
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("brake driven while off");

  property p_cut_needs_flag;
    (q.st == BPS_ENG_WAIT) && ($past(q.st) == BPS_STOP_WAIT) && q.preq && $stable(q.flags) |->
      q.flags[`BPS_BF_CUTS];
  endproperty
  a_cut_needs_flag: assert property (p_cut_needs_flag) else $error("power cut without flag");

  property p_absent_idle;
    !q.acc[`BPS_ACC_PRESENT] ##1 !q.acc[`BPS_ACC_PRESENT] |-> !brake_drive && !q.pend;
  endproperty
  a_absent_idle: assert property (p_absent_idle) else $error("absent brake sequenced");

  property p_polarity;
    q.engaged && $stable(q.acc) && $stable(q.flags) |->
      brake_drive == q.acc[`BPS_ACC_HOLD_EN];
  endproperty
  a_polarity: assert property (p_polarity) else $error("brake polarity wrong");

  property p_hold_powered;
    (q.st == BPS_HOLD) |-> q.power && q.engaged && !q.ready;
  endproperty
  a_hold_powered: assert property (p_hold_powered) else $error("hold state inconsistent");

  c_hold: cover property (q.st == BPS_HOLD);
  c_pending_go: cover property (q.go && ($past(q.st) == BPS_REL_WAIT));
  c_power_off: cover property ($fell(q.power) && ($past(q.st) == BPS_ENG_WAIT));

endmodule : brake_power_sequencer

//--- logic/bps_defs.svh
// Constant definitions for the brake and motor power sequencer.
`ifndef BPS_DEFS_SVH
`define BPS_DEFS_SVH

`define BPS_CLK_KHZ      25000
`define BPS_TICK_MS      1
`define BPS_TICK_CYC     (`BPS_CLK_KHZ * `BPS_TICK_MS)

`define BPS_REG_DLY01    3'h0
`define BPS_REG_DLY23    3'h1
`define BPS_REG_FLAGS    3'h2
`define BPS_REG_ACC      3'h3
`define BPS_REG_CTRL     3'h4
`define BPS_REG_STATUS   3'h5

`define BPS_BF_ENABLE    0
`define BPS_BF_CUTS      1
`define BPS_ACC_PRESENT  0
`define BPS_ACC_HOLD_EN  1
`define BPS_CTRL_PWR     0

`define BPS_DLY_RST      16'h0000
`define BPS_FLAGS_RST    8'h00
`define BPS_ACC_RST      32'h0000_0000
`define BPS_CTRL_RST     1'h0

`endif

//--- logic/bps_pkg.sv
// Types shared by the brake and motor power sequencer modules.
`include "bps_defs.svh"

package bps_pkg;

  typedef enum logic [2:0] {
    BPS_OFF       = 3'b000,
    BPS_PWR_WAIT  = 3'b001,
    BPS_REL_WAIT  = 3'b010,
    BPS_READY     = 3'b011,
    BPS_STOP_WAIT = 3'b100,
    BPS_ENG_WAIT  = 3'b101,
    BPS_HOLD      = 3'b110
  } bps_state_t;

  typedef struct packed {
    bps_state_t  st;
    logic [15:0] power_on_to_release_delay;
    logic [15:0] release_to_ready_delay;
    logic [15:0] stop_to_engage_delay;
    logic [15:0] engage_to_power_off_delay;
    logic [7:0]  flags;
    logic [31:0] acc;
    logic        preq;
    logic        preq_prev;
    logic        moving;
    logic        pend;
    logic        power;
    logic        engaged;
    logic        drive;
    logic        ready;
    logic        go;
    logic        wreq;
    logic [31:0] rdata;
  } bps_seq_t;

  typedef struct packed {
    logic [15:0] pre;
    logic [15:0] rem;
    logic        expired;
  } bps_tmr_t;

endpackage : bps_pkg

//--- logic/bps_tmr_if.sv
// Link between the sequencer and its millisecond delay timer.
interface bps_tmr_if;
  logic        start;
  logic [15:0] len;
  logic        done;
  modport seq (output start, output len, input done);
  modport tmr (input start, input len, output done);
endinterface : bps_tmr_if

//--- logic/bps_ms_timer.sv
// Millisecond delay timer: counts len ticks of TICK_CYCLES clocks each.
`include "bps_defs.svh"
module bps_ms_timer
  import bps_pkg::*;
#(
  parameter logic [15:0] TICK_CYCLES = 16'(`BPS_TICK_CYC)
) (
  input  wire logic ref_clk,  // System clock.
  input  wire logic rst,      // Synchronous reset, active high.
  bps_tmr_if.tmr    tmr       // Start, length and expiry.
);

  bps_tmr_t q;
  bps_tmr_t n;

  // The prescaler restarts with every load, so a delay of N is exactly N ticks long.
  always_comb begin
    n = q;
    if (tmr.start) begin
      n.pre     = 16'h0000;
      n.rem     = tmr.len;
      n.expired = (tmr.len == 16'h0000);
    end else if (!q.expired) begin
      if (q.pre == TICK_CYCLES - 16'h0001) begin
        n.pre = 16'h0000;
        n.rem = q.rem - 16'h0001;
        if (q.rem == 16'h0001) begin
          n.expired = 1'b1;
        end
      end else begin
        n.pre = q.pre + 16'h0001;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      q <= '{pre: 16'h0000, rem: 16'h0000, expired: 1'b1};
    end else begin
      q <= n;
    end
  end

  assign tmr.done = q.expired;

endmodule : bps_ms_timer

//--- verif/bps_load_model.sv
// Behavioural brake driver and motor power switch beside the sequencer.
module bps_load_model (
  input  wire logic       ref_clk,        // System clock.
  input  wire logic       rst,            // Synchronous reset, active high.
  input  wire logic       motor_power_en, // Motor power switch on.
  input  wire logic       brake_drive,    // Brake driver input.
  input  wire logic       move_go,        // Start of a move.
  input  wire logic       brake_fitted,   // Brake is under sequence control.
  input  wire logic       hold_pol,       // Brake holds while energised.
  input  wire logic [7:0] run_len,        // Move length in cycles.
  output logic            motion_active,  // Motor is moving.
  output logic            fault           // Moved against a held brake or without power.
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] left_q;
  logic       held;
  // A move that starts while the brake still holds tears the load, so it is latched as a fault.
  assign held = brake_fitted & (hold_pol ? brake_drive : ~brake_drive);
  assign motion_active = (left_q != 8'h00);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      left_q <= 8'h00;
      fault  <= 1'b0;
    end else begin
      if (move_go)
        left_q <= run_len;
      else if (left_q != 8'h00)
        left_q <= left_q - 8'h01;
      if (motion_active && (held || !motor_power_en))
        fault <= 1'b1;
    end
  end
endmodule : bps_load_model

//--- verif/brake_power_sequencer_tb.sv
// Self-checking testbench for the brake and motor power sequencer.
module brake_power_sequencer_tb;
  import bps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] TICK = 16'h0004;
  logic        ref_clk, rst, avs_read, avs_write, move_cmd, motion_active;
  logic [2:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd_data;
  logic        avs_waitrequest, motor_power_en, brake_drive, move_ready, move_go;
  logic        hold_pol, seq_on, fault;
  logic [7:0]  run_len;
  logic [15:0] t[4];
  logic [31:0] exp_q[$];
  int          num_errors, check_count, cyc, n;
  event        rd_done;

  brake_power_sequencer #(.TICK_CYCLES(TICK)) dut_u (.ref_clk(ref_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .move_cmd(move_cmd), .motion_active(motion_active),
    .motor_power_en(motor_power_en), .brake_drive(brake_drive), .move_ready(move_ready),
    .move_go(move_go));
  bps_load_model load_u (.ref_clk(ref_clk), .rst(rst), .motor_power_en(motor_power_en),
    .brake_drive(brake_drive), .move_go(move_go), .brake_fitted(seq_on),
    .hold_pol(hold_pol), .run_len(run_len), .motion_active(motion_active), .fault(fault));

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  // Read results are compared in arrival order against the notes of the driver.
  initial forever begin
    @(rd_done);
    check(rd_data, exp_q.pop_front(), "read data");
  end

  task automatic bus(input logic wr, input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    avs_read      <= !wr;
    avs_write     <= wr;
    avs_address   <= a;
    avs_writedata <= d;
    // Waitrequest is read as it stood at the edge; the access completes where it is low.
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd_data = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (!wr)
      ->rd_done;
  endtask : bus

  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd

  task automatic pulse;
    @(posedge ref_clk);
    move_cmd <= 1'b1;
    @(posedge ref_clk);
    move_cmd <= 1'b0;
  endtask : pulse

  task automatic do_reset;
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
  endtask : do_reset

  function automatic logic cond(input int k);
    case (k)
      0: return motor_power_en;
      1: return brake_drive === ~hold_pol;
      2: return move_ready;
      3: return !motion_active;
      4: return brake_drive === hold_pol;
      default: return !motor_power_en;
    endcase
  endfunction : cond

  task automatic wait_on(input int k, output int cnt);
    cnt = 0;
    #1;
    while (cond(k) !== 1'b1) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
  endtask : wait_on

  task automatic run_seq(input logic [7:0] flg, input logic [31:0] acc, input logic ctl);
    foreach (t[i]) t[i] = 16'($urandom_range(1, 3));
    run_len  = 8'($urandom_range(2, 40));
    seq_on   = 1'b1;
    hold_pol = acc[1];
    bus(1'b1, 3'h0, {t[1], t[0]});
    bus(1'b1, 3'h1, {t[3], t[2]});
    bus(1'b1, 3'h2, {24'h0, flg});
    bus(1'b1, 3'h3, acc);
    rd(3'h1, {t[3], t[2]});
    rd(3'h3, acc);
    if (ctl)
      bus(1'b1, 3'h4, 32'h1);
    // The command arrives while power comes up, so it must be held until ready.
    fork
      pulse();
      begin
        wait_on(0, n);
        check(brake_drive, hold_pol, "held at power on");
        wait_on(1, n);
        check(n, t[0] * TICK + 1, "power to release");
      end
    join
    wait_on(2, n);
    check(n, t[1] * TICK + 1, "release to ready");
    check(move_go, 1'b1, "pending command");
    @(posedge ref_clk);
    wait_on(3, n);
    wait_on(4, n);
    // The stop is sampled one edge after motion_active falls.
    check(n, t[2] * TICK + 2, "stop to engage");
    check(move_ready, 1'b0, "ready after engage");
    if (flg[1] | !ctl) begin
      wait_on(5, n);
      check(n, t[3] * TICK + 1, "engage to power off");
    end else begin
      repeat (t[3] * TICK + 8) @(posedge ref_clk);
      #1;
      check(motor_power_en, 1'b1, "power kept");
    end
    check(fault, 1'b0, "move against brake");
    $display("test sequence flags %h done", flg);
  endtask : run_seq

  task automatic run_off(input logic [7:0] flg, input logic [31:0] acc);
    seq_on = 1'b0;
    bus(1'b1, 3'h2, {24'h0, flg});
    bus(1'b1, 3'h3, acc);
    bus(1'b1, 3'h4, 32'h1);
    repeat (3) @(posedge ref_clk);
    #1;
    check(motor_power_en, 1'b1, "power follows request");
    check(brake_drive, 1'b0, "brake untouched");
    check(move_ready, 1'b1, "ready follows request");
    pulse();
    #1;
    check(move_go, 1'b1, "command passes through");
    $display("test inactive flags %h done", flg);
  endtask : run_off

  initial begin
    rst           = 1'b1;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_address   = 3'h0;
    avs_writedata = 32'h0;
    move_cmd      = 1'b0;
    hold_pol      = 1'b0;
    seq_on        = 1'b0;
    run_len       = 8'h04;
    void'($urandom(32'h6224));
    do_reset();
    for (int a = 0; a < 8; a++) rd(3'(a), 32'h0);
    bus(1'b1, 3'h6, 32'hffff_ffff);
    bus(1'b1, 3'h5, 32'hffff_ffff);
    rd(3'h6, 32'h0);
    rd(3'h5, 32'h0);
    check(motor_power_en, 1'b0, "power at reset");
    $display("test registers done");
    run_seq(8'h03, 32'h1, 1'b1);
    do_reset();
    run_seq(8'h01, 32'h3, 1'b1);
    do_reset();
    run_seq(8'h01, 32'h1, 1'b0);
    do_reset();
    run_off(8'h00, 32'h1);
    do_reset();
    run_off(8'h01, 32'h2);
    repeat (4) @(posedge ref_clk);
    print_verdict();
  end
endmodule : brake_power_sequencer_tb
